// ### rtl/fmu_host.sv
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`include "fmu_defines.svh"
module fmu_host (
    input wire logic clk_i,
    input wire logic rst_i,
    fmu_if.host bus,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    typedef enum logic [3:0] {
        FMU_IDLE = 4'h1,
        FMU_REQ = 4'h2,
        FMU_WAIT = 4'h4,
        FMU_NEXT = 4'h8
    } fmu_state_t;
    fmu_state_t st_q;
    logic [7:0] cmd_addr_q;
    logic cmd_we_q;
    logic [7:0] cmd_wdata_q;
    logic [7:0] rd_q;
    logic busy_q;
    logic done_q;
    logic req_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [37:0] mult_q;
    wire [7:0] link_w = cmd_we_q ? cmd_wdata_q : bus.rdata;
    wire wb_go_w = wb_cyc_i && wb_stb_i && !ack_q;
    wire wr_w = wb_go_w && wb_we_i && wb_sel_i[0];
    wire start_w = wr_w && (wb_adr_i == `FMU_WB_CMD) && !busy_q;
    wire [31:0] stat_w = {22'h0, done_q, busy_q, rd_q};
    wire [31:0] rsel_w = (wb_adr_i == `FMU_WB_STAT) ? stat_w :
        (wb_adr_i == `FMU_WB_DATA) ? {24'h0, cmd_wdata_q} :
        (wb_adr_i == `FMU_WB_MULT_LO) ? mult_q[31:0] :
        (wb_adr_i == `FMU_WB_CMD) ? {22'h0, cmd_we_q, 1'b0, cmd_addr_q} :
        32'h00000000;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
            cmd_wdata_q <= 8'h00;
        end
        else
        begin
            ack_q <= wb_go_w;
            if (wb_go_w && !wb_we_i)
                dat_q <= rsel_w;
            if (wr_w && wb_adr_i == `FMU_WB_DATA && !busy_q)
                cmd_wdata_q <= wb_dat_i[7:0];
        end
    end
    // Byte transfer engine; software sequences 5-7, 8, then 9 last
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= FMU_IDLE;
            cmd_addr_q <= 8'h00;
            cmd_we_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            req_q <= 1'b0;
            rd_q <= 8'h00;
            mult_q <= 38'h0;
        end
        else
        begin
            case (st_q)
                FMU_IDLE:
                begin
                    if (start_w)
                    begin
                        cmd_addr_q <= wb_dat_i[7:0];
                        cmd_we_q <= wb_dat_i[9];
                        busy_q <= 1'b1;
                        done_q <= 1'b0;
                        req_q <= 1'b1;
                        st_q <= FMU_REQ;
                    end
                end
                FMU_REQ:
                    st_q <= FMU_WAIT;
                FMU_WAIT:
                begin
                    if (bus.ack)
                    begin
                        req_q <= 1'b0;
                        if (!cmd_we_q)
                            rd_q <= bus.rdata;
                        // Track each byte read or written at addresses 05..09; other addresses leave mult_q unchanged
                        case (cmd_addr_q)
                            `FMU_REG_FRAC0: mult_q[7:0] <= link_w;
                            `FMU_REG_FRAC1: mult_q[15:8] <= link_w;
                            `FMU_REG_FRAC2: mult_q[23:16] <= link_w;
                            `FMU_REG_INTLO: mult_q[31:24] <= link_w;
                            `FMU_REG_INTHI: mult_q[37:32] <= link_w[5:0];
                            default: mult_q <= mult_q;
                        endcase
                        st_q <= FMU_NEXT;
                    end
                end
                FMU_NEXT:
                begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    st_q <= FMU_IDLE;
                end
                default:
                    st_q <= FMU_IDLE;
            endcase
        end
    end
    // Range, scaling and re-centering are software's job
    assign bus.req = req_q;
    assign bus.we = cmd_we_q;
    assign bus.addr = cmd_addr_q;
    assign bus.wdata = cmd_wdata_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
endmodule : fmu_host

// ### include/fmu_defines.svh
`ifndef FMU_DEFINES_SVH
`define FMU_DEFINES_SVH
`define FMU_ADDR_W 8
`define FMU_REG_FRAC0 8'h05
`define FMU_REG_FRAC1 8'h06
`define FMU_REG_FRAC2 8'h07
`define FMU_REG_INTLO 8'h08
`define FMU_REG_INTHI 8'h09
`define FMU_INT_W 9
`define FMU_FRAC_W 29
`define FMU_MULT_W 38
`define FMU_INTLO_MSB 7
`define FMU_INTLO_LSB 5
`define FMU_FRACHI_MSB 4
`define FMU_INTHI_MSB 5
`define FMU_XTAL_KHZ 31980
`define FMU_SETTLE_US 100
`define FMU_CLK_MHZ 10
`define FMU_SETTLE_CYC (`FMU_SETTLE_US * `FMU_CLK_MHZ)
`define FMU_INIT_MULT 38'h9497c65d3
`define FMU_INIT_HSD 10'h010
`define FMU_INIT_LSD 3'h0
`define FMU_WB_CMD 4'h0
`define FMU_WB_DATA 4'h4
`define FMU_WB_STAT 4'h8
`define FMU_WB_MULT_LO 4'hc
`define FMU_CMD_READ 2'h1
`define FMU_CMD_WRITE 2'h2
`endif

// ### include/fmu_pkg.sv
package fmu_pkg;
    typedef logic [7:0] fmu_byte_t;
    typedef logic [37:0] fmu_mult_t;
endpackage : fmu_pkg

// ### include/fmu_if.sv
`timescale 1ns/1ps
interface fmu_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;
    modport dev (input req, we, addr, wdata, output rdata, ack);
    modport host (output req, we, addr, wdata, input rdata, ack);
endinterface : fmu_if

// ### rtl/fmu_device.sv
`timescale 1ns/1ps
`include "fmu_defines.svh"
module fmu_device #(
    parameter int SETTLE_CYC = `FMU_SETTLE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    fmu_if.dev bus,
    input wire logic [9:0] high_speed_divider_i,
    input wire logic [2:0] low_speed_divider_i,
    output logic [37:0] active_mult_o,
    output logic [31:0] freq_out_khz_o,
    output logic settling_o
);
    // Settle counter is 16 bits wide
    if (SETTLE_CYC < 1 || SETTLE_CYC > 65536)
    begin : g_bad_settle
        $error("SETTLE_CYC must lie between 1 and 65536");
    end
    fmu_pkg::fmu_byte_t hold_q [0:4];
    fmu_pkg::fmu_mult_t act_q;
    logic ack_q;
    logic [7:0] rdata_q;
    logic [31:0] freq_q;
    logic [15:0] settle_q;
    logic settling_q;
    // Current multiplier as integer and fraction
    wire [8:0] int_w = act_q[37:29];
    wire [28:0] frac_w = act_q[28:0];
    // Holding bytes start as the active multiplier
    wire [37:0] init_w = `FMU_INIT_MULT;
    wire take_w = bus.req && !ack_q;
    wire [7:0] idx_w = bus.addr - `FMU_REG_FRAC0;
    wire hit_w = (bus.addr >= `FMU_REG_FRAC0) && (bus.addr <= `FMU_REG_INTHI);
    wire commit_w = take_w && bus.we && (bus.addr == `FMU_REG_INTHI);
    // Assembled multiplier from holding bytes plus new top byte
    wire [37:0] new_mult_w = {bus.wdata[`FMU_INTHI_MSB:0],
        hold_q[3][`FMU_INTLO_MSB:`FMU_INTLO_LSB],
        hold_q[3][`FMU_FRACHI_MSB:0],
        hold_q[2], hold_q[1], hold_q[0]};
    wire [19:0] div_w = {10'h000, high_speed_divider_i} << low_speed_divider_i;
    wire [63:0] num_w = 64'(`FMU_XTAL_KHZ) * 64'(act_q);
    wire [63:0] fq_w = (num_w >> `FMU_FRAC_W) / 64'(div_w);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hold_q[0] <= init_w[7:0];
            hold_q[1] <= init_w[15:8];
            hold_q[2] <= init_w[23:16];
            hold_q[3] <= init_w[31:24];
            hold_q[4] <= {2'h0, init_w[37:32]};
            act_q <= `FMU_INIT_MULT;
            ack_q <= 1'b0;
            rdata_q <= 8'h00;
        end
        else
        begin
            ack_q <= take_w;
            if (take_w && bus.we && hit_w && !commit_w)
                hold_q[idx_w[2:0]] <= bus.wdata;
            if (commit_w)
            begin
                hold_q[4] <= {2'h0, bus.wdata[`FMU_INTHI_MSB:0]};
                act_q <= new_mult_w;
            end
            if (take_w && !bus.we)
                rdata_q <= hit_w ? hold_q[idx_w[2:0]] : 8'h00;
        end
    end
    // No recalibration path: multiplier updates glide without reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            settle_q <= 16'h0000;
            settling_q <= 1'b0;
            freq_q <= 32'h00000000;
        end
        else
        begin
            freq_q <= fq_w[31:0];
            if (commit_w)
            begin
                settle_q <= 16'(SETTLE_CYC - 1);
                settling_q <= 1'b1;
            end
            else if (settle_q != 16'h0000)
                settle_q <= settle_q - 16'h0001;
            else
                settling_q <= 1'b0;
        end
    end
    assign bus.ack = ack_q;
    assign bus.rdata = rdata_q;
    assign active_mult_o = act_q;
    assign freq_out_khz_o = freq_q;
    assign settling_o = settling_q;
    wire unused_w = &{1'b0, int_w, frac_w};
endmodule : fmu_device

// ### bench/fmu_asserts.sv
`timescale 1ns/1ps
module fmu_asserts #(
    parameter int SETTLE_CYC = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack,
    input wire logic [37:0] active_mult_o,
    input wire logic settling_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic [15:0] cnt_q;
    logic [7:0] cw_q;
    wire commit = req && we && addr == 8'h09 && !ack;
    always_ff @(posedge clk_i)
    begin
        cnt_q <= settling_o ? cnt_q + 16'h1 : 16'h0;
        cw_q <= commit ? wdata : cw_q;
    end
    sequence s_commit;
        req && we && addr == 8'h09 && !ack;
    endsequence
    a_ack_pulse: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(ack) |-> $past(req))
        else $error("ack without request");
    a_ack_bound: assert property (req && !ack |-> ##[1:3] ack)
        else $error("request not answered");
    a_rdata_hold: assert property (!ack |-> $stable(rdata))
        else $error("read data moved without ack");
    a_mult_commit: assert property ($changed(active_mult_o)
        |-> $past(commit) || $past(commit, 2))
        else $error("multiplier moved without commit");
    a_commit_int: assert property (s_commit
        |-> ##[1:2] active_mult_o[37:32] == cw_q[5:0])
        else $error("integer high bits not applied");
    a_settle_rise: assert property (s_commit |-> ##[1:3] settling_o)
        else $error("settling not raised");
    a_settle_max: assert property (cnt_q <= SETTLE_CYC)
        else $error("settling too long");
    a_settle_min: assert property ($fell(settling_o)
        |-> cnt_q >= SETTLE_CYC)
        else $error("settling too short");
endmodule : fmu_asserts

// ### bench/tb.sv
`timescale 1ns/1ps
`include "fmu_defines.svh"
module tb;
    localparam int SC = 40;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic wwe = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic ack;
    logic [9:0] hsd = 10'h010;
    logic [2:0] lsd = 3'h0;
    fmu_pkg::fmu_mult_t mult;
    logic [31:0] khz;
    logic settling;
    logic [31:0] r;
    logic [7:0] wr [5] = '{8'h85, 8'hcf, 8'h1d, 8'h47, 8'h09};
    logic [7:0] init_rd [5] = '{8'hd3, 8'h65, 8'h7c, 8'h49, 8'h09};
    int miscompares = 0;
    int cmp_count = 0;
    fmu_if bus();
    fmu_device #(.SETTLE_CYC(SC)) u_fmu_device (.clk_i(clk_i),
        .rst_i(rst_i), .bus(bus), .high_speed_divider_i(hsd),
        .low_speed_divider_i(lsd), .active_mult_o(mult),
        .freq_out_khz_o(khz), .settling_o(settling));
    fmu_host u_fmu_host (.clk_i(clk_i), .rst_i(rst_i), .bus(bus),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack));
    fmu_asserts #(.SETTLE_CYC(SC)) u_fmu_asserts (.clk_i(clk_i),
        .rst_i(rst_i), .req(bus.req), .we(bus.we), .addr(bus.addr),
        .wdata(bus.wdata), .rdata(bus.rdata), .ack(bus.ack),
        .active_mult_o(mult), .settling_o(settling));
    initial
    begin
        forever #50 clk_i = ~clk_i;
    end
    task automatic stop_test();
        $display("compares %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string n, input logic [37:0] e,
        input logic [37:0] s);
        cmp_count++;
        if (s !== e)
        begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        wwe <= w;
        sel <= 4'hf;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
    endtask : wb
    task automatic lk(input logic w, input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, 4'h4, {24'h0, d});
        wb(1'b1, 4'h0, {22'h0, w, 1'b0, a});
        do wb(1'b0, 4'h8, 32'h0); while (r[9:8] !== 2'b10);
    endtask : lk
    task automatic settle();
        int n;
        n = 0;
        chk("settling", 38'h1, {37'h0, settling});
        while (settling !== 1'b0)
        begin
            @(posedge clk_i);
            n++;
        end
        chk("settle_len", 38'h1, {37'h0, n <= SC});
    endtask : settle
    function automatic logic [37:0] fx(input logic [37:0] m);
        return 38'((64'd31980 * m) / ({54'h0, hsd} << (29 + lsd)));
    endfunction : fx
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("init", `FMU_INIT_MULT, mult);
        for (int k = 0; k < 5; k++)
        begin
            lk(1'b0, 8'h05 + 8'(k), 8'h00);
            chk("reset_rd", {30'h0, init_rd[k]}, {30'h0, r[7:0]});
        end
        for (int k = 0; k < 4; k++)
        begin
            lk(1'b1, 8'h05 + 8'(k), wr[k]);
        end
        chk("hold", `FMU_INIT_MULT, mult);
        lk(1'b1, 8'h09, wr[4]);
        chk("mult", {9'd74, 29'h071dcf85}, mult);
        wb(1'b0, 4'hc, 32'h0);
        chk("host_mult", 38'h0471dcf85, {6'h0, r});
        settle();
        for (int k = 0; k < 3; k++)
        begin
            lsd <= 3'(k);
            repeat (3) @(posedge clk_i);
            chk("khz", fx(mult), {6'h0, khz});
        end
        for (int k = 0; k < 5; k++)
        begin
            lk(1'b0, 8'h05 + 8'(k), 8'h00);
            chk("readback", {30'h0, wr[k]}, {30'h0, r[7:0]});
        end
        lk(1'b1, 8'h05, 8'h00);
        lk(1'b1, 8'h09, 8'h09);
        chk("partial", {9'd74, 29'h071dcf00}, mult);
        settle();
        wb(1'b0, 4'h4, 32'h0);
        chk("data_rd", 38'h09, {6'h0, r});
        lk(1'b0, 8'h0a, 8'h00);
        chk("unmapped", 38'h0, {30'h0, r[7:0]});
        wb(1'b0, 4'h0, 32'h0);
        chk("cmd_rd", 38'h0a, {6'h0, r});
        stop_test();
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        stop_test();
    end
endmodule : tb
